// ==== logic/rts_pkg.sv ====
// Package for the reader trigger sequencer: timing counts, modes, carriers.
// Assumes a 40 MHz clock; all times are turned into cycle counts here.
package rts_pkg;
    // Clock rate and derived per-millisecond count
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_CYC = CLK_HZ / 1000;
    // Delay from read end to result output, in milliseconds
    localparam int RESULT_DELAY_MS = 5;
    localparam int RESULT_DELAY_CYC = RESULT_DELAY_MS * MS_CYC;
    // Result on-time step is 10 ms; code 1..255 gives 10 ms..2.55 s
    localparam int RESULT_STEP_MS = 10;
    localparam int RESULT_STEP_CYC = RESULT_STEP_MS * MS_CYC;
    localparam logic [7:0] RESULT_CODE_MIN = 8'h01;
    localparam logic [7:0] RESULT_CODE_MAX = 8'hFF;
    // Qualification/one-shot input time step is 1 ms
    localparam int INPUT_STEP_MS = 1;
    localparam int INPUT_STEP_CYC = INPUT_STEP_MS * MS_CYC;
    // Symbology slots and multi-3 bounds
    localparam int SYMB_SLOTS = 4;
    localparam int MULTI3_MIN = 2;
    localparam int MULTI3_MAX = 4;

    // Read modes
    typedef enum logic [1:0] {
        RTS_SINGLE = 2'h0,
        RTS_MULTI1 = 2'h1,
        RTS_MULTI2 = 2'h2,
        RTS_MULTI3 = 2'h3
    } rts_mode_type;

    // Sequencer states, Gray coded along idle-qualify-read-wait-pulse
    typedef enum logic [2:0] {
        RTS_IDLE = 3'h0,
        RTS_QUAL = 3'h1,
        RTS_READ = 3'h3,
        RTS_WAIT = 3'h2,
        RTS_PULSE = 3'h6
    } rts_state_type;

    // Configuration carried as one group
    typedef struct packed {
        logic one_shot;
        logic send_at_trigger;
        rts_mode_type mode;
        logic [7:0] decode_count;
        logic [7:0] input_time_ms;
        logic [7:0] result_on_code;
        logic [3:0] symb_enable;
        logic compare_valid;
    } rts_cfg_type;

    // Decoder report carried as one group
    typedef struct packed {
        logic valid;
        logic [1:0] slot;
        logic match;
    } rts_dec_type;
endpackage

// ==== logic/rts_sequencer.sv ====
// Reader trigger sequencer: trigger qualification, illumination, decode
// counting, send strobe and pass/fail result timing.
// Assumes the decoder core and serial framer sit outside and use the
// strobes given here; all inputs except read_trigger_in are synchronous to clock.
`timescale 1ns/10ps

// Notes on behaviour
// R1 - Level trigger: active trigger switches illumination on and starts decoding.
// R2 - Trigger must stay active beyond the qualification time before illumination.
// R3 - Illumination off when decode count reached, then data is sent.
// R4 - Pass/fail on-time programmable from 10 ms to 2.55 s.
// R5 - Result 5 ms after good read, or after trigger release on failure.
// R6 - One-shot: rising edge starts a read lasting the configured input time.
// R7 - Host holds level trigger long enough; uses one-shot for short pulses.
// R8 - Up to four symbology slots decoded without changing the setup.
// R9 - Send mode selectable only in single-label; multi modes send after read.
// R10 - Send-after-read: result issued once decode count is achieved.
// R11 - Send-at-trigger: result issued at trigger release or one-shot expiry.
// R12 - Request-to-send output is held permanently asserted.
// R13 - Pass/fail shows compare match, or plain read success without compare data; the code ignores compare data in multi modes.
// R14 - Multi-3 decodes two to four codes present together in the field; the code also completes multi-3 with a single enabled slot.
// R15 - Trigger input is synchronised before edge detection or timing.
module rts_sequencer #(
    // Cycles per millisecond; lowered only to keep simulations short
    parameter int CYC_PER_MS = rts_pkg::MS_CYC
) (
    // Clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Host pins
    input wire logic read_trigger_in,
    output logic pass_result_out,
    output logic fail_result_out,
    output logic rts_out,
    // Configuration
    input wire rts_pkg::rts_cfg_type cfg,
    // Decoder side
    input wire rts_pkg::rts_dec_type dec,
    output logic illum_on,
    output logic decode_en,
    output logic [3:0] decode_slots,
    output logic send_strobe
);
    import rts_pkg::*;

    // Millisecond-based times scaled by the clock rate parameter
    localparam int DELAY_CYC = RESULT_DELAY_MS * CYC_PER_MS;
    localparam int STEP_CYC = RESULT_STEP_MS * CYC_PER_MS;
    localparam int IN_CYC = INPUT_STEP_MS * CYC_PER_MS;

    rts_state_type state_q, state_d;
    logic sync1_q, sync2_q, trig_q;
    logic [31:0] timer_q, timer_d;
    logic [31:0] hold_q, hold_d;
    logic [7:0] good_q, good_d;
    logic [3:0] seen_q, seen_d;
    logic match_q, match_d;
    logic pass_q, pass_d, fail_q, fail_d, send_q, send_d;
    logic trig_on, trig_off, trig_rise, single, multi3;
    logic count_met, success, early_send;
    logic [31:0] qual_cyc, on_cyc;
    logic [2:0] need3;
    logic [7:0] code_sat;

    // Two-flop synchroniser; only sync2 and later feed logic
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            trig_q <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= read_trigger_in; // R15
            sync2_q <= sync1_q; // R15
            trig_q <= sync2_q;
        end
    end

    assign trig_on = sync2_q;
    assign trig_off = trig_q & ~sync2_q;
    assign trig_rise = sync2_q & ~trig_q; // R6
    assign single = (cfg.mode == RTS_SINGLE);
    assign multi3 = (cfg.mode == RTS_MULTI3);
    assign qual_cyc = 32'(cfg.input_time_ms) * 32'(IN_CYC);
    // Code zero would give only a one-cycle pulse, so it is lifted to 10 ms
    assign code_sat = (cfg.result_on_code < RESULT_CODE_MIN) ?
        RESULT_CODE_MIN : cfg.result_on_code;
    assign on_cyc = 32'(code_sat) * 32'(STEP_CYC); // R4
    assign need3 = 3'(cfg.symb_enable[0]) + 3'(cfg.symb_enable[1]) +
        3'(cfg.symb_enable[2]) + 3'(cfg.symb_enable[3]);
    // Multi-3 completes when every enabled slot has been seen
    assign count_met = multi3 ?
        ((seen_q & cfg.symb_enable) == cfg.symb_enable && need3 != 3'h0) :
        (good_q >= cfg.decode_count && cfg.decode_count != 8'h00);
    // Multi modes ignore the send-at-trigger option
    assign early_send = ~(single & cfg.send_at_trigger); // R9
    assign success = multi3 ? count_met : (good_q != 8'h00);

    // Sequencer next-state logic
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        hold_d = hold_q;
        good_d = good_q;
        seen_d = seen_q;
        match_d = match_q;
        pass_d = pass_q;
        fail_d = fail_q;
        send_d = 1'b0;
        unique case (state_q)
            RTS_IDLE: begin
                timer_d = 32'h0;
                if ((cfg.one_shot && trig_rise) ||
                    (!cfg.one_shot && trig_on)) begin
                    state_d = RTS_QUAL;
                end
            end
            RTS_QUAL: begin
                // Level trigger must stay on; one-shot only needs the edge
                if (!cfg.one_shot && !trig_on) begin
                    state_d = RTS_IDLE;
                end else if (timer_q >= qual_cyc) begin // R2
                    state_d = RTS_READ; // R1 R6
                    timer_d = 32'h0;
                    good_d = 8'h00;
                    seen_d = 4'h0;
                    match_d = 1'b1;
                end else begin
                    timer_d = timer_q + 32'h1;
                end
            end
            RTS_READ: begin
                timer_d = timer_q + 32'h1;
                if (dec.valid && cfg.symb_enable[dec.slot]) begin // R8
                    if (!multi3 || !seen_q[dec.slot]) begin // R14
                        good_d = good_q + 8'h01;
                    end
                    seen_d = seen_q | (4'h1 << dec.slot);
                    match_d = match_q & (dec.match | ~cfg.compare_valid);
                end
                if (count_met && early_send) begin // R3 R10
                    state_d = RTS_WAIT;
                    timer_d = 32'h0;
                    send_d = 1'b1;
                end else if ((cfg.one_shot && timer_q >= qual_cyc) ||
                             (!cfg.one_shot && trig_off)) begin // R11
                    state_d = RTS_WAIT;
                    timer_d = 32'h0;
                    send_d = 1'b1;
                end
            end
            RTS_WAIT: begin
                // Fixed gap between end of read and result pulse
                if (timer_q >= 32'(DELAY_CYC - 1)) begin // R5
                    state_d = RTS_PULSE;
                    timer_d = 32'h0;
                    hold_d = on_cyc;
                    // Multi modes skip the compare data
                    pass_d = success &
                        (match_q | ~cfg.compare_valid | ~single); // R13
                    fail_d = ~(success &
                        (match_q | ~cfg.compare_valid | ~single)); // R13
                end else begin
                    timer_d = timer_q + 32'h1;
                end
            end
            RTS_PULSE: begin
                if (hold_q <= 32'h1) begin // R4
                    pass_d = 1'b0;
                    fail_d = 1'b0;
                    // Wait for level trigger release so one hold is one read
                    if (cfg.one_shot || !trig_on) begin
                        state_d = RTS_IDLE;
                    end
                end else begin
                    hold_d = hold_q - 32'h1;
                end
            end
            default: state_d = RTS_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= RTS_IDLE;
            timer_q <= 32'h0;
            hold_q <= 32'h0;
            good_q <= 8'h00;
            seen_q <= 4'h0;
            match_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            send_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            timer_q <= timer_d;
            hold_q <= hold_d;
            good_q <= good_d;
            seen_q <= seen_d;
            match_q <= match_d;
            pass_q <= pass_d;
            fail_q <= fail_d;
            send_q <= send_d;
        end
    end

    // Outputs
    assign illum_on = (state_q == RTS_READ); // R1 R3
    assign decode_en = (state_q == RTS_READ);
    assign decode_slots = cfg.symb_enable; // R8
    assign send_strobe = send_q;
    assign pass_result_out = pass_q;
    assign fail_result_out = fail_q;
    assign rts_out = 1'b1; // R12

    a_rts_fixed: assert property (@(posedge clock) disable iff (!rst_n)
        rts_out == 1'b1) else $error("rts not asserted"); // R12
    a_illum_needs_qual: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(illum_on) |-> $past(state_q) == RTS_QUAL)
        else $error("illumination without qualification"); // R2
    a_send_ends_read: assert property (@(posedge clock) disable iff (!rst_n)
        send_strobe |-> !illum_on) else $error("send while lit"); // R3
    a_result_excl: assert property (@(posedge clock) disable iff (!rst_n)
        !(pass_result_out && fail_result_out))
        else $error("pass and fail together"); // R13
    a_result_after_wait: assert property (@(posedge clock)
        disable iff (!rst_n)
        $rose(pass_result_out) || $rose(fail_result_out) |->
        $past(state_q) == RTS_WAIT) else $error("result early"); // R5
    a_early_send: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_q == RTS_READ && count_met && early_send
        |=> send_strobe) else $error("send after read missed"); // R10
    a_level_start: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_q == RTS_IDLE && !cfg.one_shot && trig_on
        |=> state_q == RTS_QUAL) else $error("trigger not taken"); // R1
    a_oneshot_edge: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_q == RTS_IDLE && cfg.one_shot && !trig_rise
        |=> state_q == RTS_IDLE) else $error("one-shot without edge"); // R6
    a_trig_release: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_q == RTS_READ && !cfg.one_shot && trig_off
        |=> state_q == RTS_WAIT) else $error("release not ending read"); // R11
endmodule

// ==== testbench/rts_host.sv ====
// Host controller model: drives the trigger line, watches request-to-send.
// Assumes the bench commands the trigger level through hold_req.
`timescale 1ns/10ps
module rts_host (
    // Clock
    input wire logic clock,
    // Bench command and device pins
    input wire logic hold_req,
    input wire logic rts_out,
    output logic read_trigger_in,
    output logic rts_dropped
);
    // Trigger follows the command one clock later; the bench drops it after each read
    always_ff @(posedge clock) begin
        read_trigger_in <= hold_req;
    end
    // Sticky flag, since a single late sample would hide a short drop
    initial rts_dropped = 1'b0;
    always @(posedge clock) begin
        if (rts_out !== 1'b1) rts_dropped <= 1'b1;
    end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the reader trigger sequencer.
// Assumes the host model drives the trigger; the design runs with a short
// millisecond so that every read stays a few hundred cycles long.
`timescale 1ns/10ps
module tb;
    import rts_pkg::*;
    typedef struct {
        rts_mode_type mode; logic sat; logic cmp; logic mt;
        logic [3:0] en; logic [7:0] dc; int n; logic ex_pass;
    } rts_row_type;
    logic clock = 1'b0, rst_n = 1'b0, hold = 1'b0, trig, pass, fail, rts;
    // Cycles per millisecond given to the design
    localparam int TB_MS = 20;
    logic illum, dec_en, strobe, rts_drop, res, ce = 1'b1;
    logic [3:0] slots;
    rts_cfg_type cfg = '0;
    rts_dec_type dec = '0;
    int fails = 0, comparisons = 0;
    int n0;
    rts_row_type rows[4] = '{
        '{RTS_SINGLE, 1'b0, 1'b0, 1'b0, 4'hF, 8'h01, 1, 1'b1},
        '{RTS_SINGLE, 1'b0, 1'b1, 1'b0, 4'hF, 8'h01, 1, 1'b0},
        '{RTS_MULTI3, 1'b1, 1'b0, 1'b0, 4'h3, 8'h02, 2, 1'b1},
        '{RTS_SINGLE, 1'b1, 1'b0, 1'b0, 4'hF, 8'h01, 1, 1'b1}};

    always #12.5 clock = ~clock;
    assign res = pass | fail;

    rts_sequencer #(.CYC_PER_MS(TB_MS)) i_dut (.clock(clock), .rst_n(rst_n),
        .clk_en(ce), .read_trigger_in(trig), .pass_result_out(pass),
        .fail_result_out(fail), .rts_out(rts), .cfg(cfg), .dec(dec),
        .illum_on(illum), .decode_en(dec_en), .decode_slots(slots),
        .send_strobe(strobe));
    rts_host i_host (.clock(clock), .hold_req(hold), .rts_out(rts),
        .read_trigger_in(trig), .rts_dropped(rts_drop));

    task automatic summarize();
        $display("Comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return illum;
            1: return strobe;
            default: return res;
        endcase
    endfunction
    // Bounded wait; running out ends the run as a failure
    task automatic wait_sig(input int w, input logic v, input int lim,
                            output int n);
        n = 0;
        while (pick(w) !== v) begin
            tick();
            n++;
            if (n > lim) begin
                fails++;
                summarize();
            end
        end
    endtask
    // One read: configure, trigger, decode, then time the result pulse
    task automatic run_read(input rts_row_type r, input logic os);
        int n;
        cfg <= '{one_shot:os, send_at_trigger:r.sat, mode:r.mode,
            decode_count:r.dc, input_time_ms:{7'h00, os},
            result_on_code:8'h01, symb_enable:r.en, compare_valid:r.cmp};
        hold <= 1'b1;
        tick();
        if (os) hold <= 1'b0;
        wait_sig(0, 1'b1, 1000, n);
        chk_val(dec_en, 1'b1);
        chk_val(slots, r.en);
        for (int i = 0; i < r.n; i++) begin
            dec <= '{valid:1'b1, slot:i[1:0], match:r.mt};
            tick();
            dec.valid <= 1'b0;
            tick();
        end
        if (r.sat && r.mode == RTS_SINGLE) begin
            repeat (8) tick();
            chk_val(strobe, 1'b0);
            hold <= 1'b0;
        end
        wait_sig(1, 1'b1, 1000, n);
        hold <= 1'b0;
        tick();
        chk_val(illum, 1'b0);
        wait_sig(2, 1'b1, 1000, n);
        chk_cnt(n + 1, RESULT_DELAY_MS * TB_MS);
        chk_val(pass, r.ex_pass);
        chk_val(fail, !r.ex_pass);
        wait_sig(2, 1'b0, 1000, n);
        chk_cnt(n, RESULT_STEP_MS * TB_MS);
        repeat (4) tick();
    endtask

    initial begin
        repeat (20) tick();
        chk_val({pass, fail, illum, strobe}, 8'h00);
        chk_val(rts, 1'b1);
        rst_n <= 1'b1;
        tick();
        // Ordinary reads from the table
        foreach (rows[k]) begin
            run_read(rows[k], 1'b0);
            $display("Test %0d done", k);
        end
        // One-shot pulse with no decode: window expiry gives a fail
        run_read('{RTS_SINGLE, 1'b1, 1'b0, 1'b0, 4'h1, 8'h01, 0, 1'b0},
            1'b1);
        $display("Test one-shot done");
        // Level trigger with 1 ms qualification, then frozen, then reset
        cfg.one_shot <= 1'b0;
        hold <= 1'b1;
        wait_sig(0, 1'b1, 1000, n0);
        chk_val(n0 > INPUT_STEP_MS * TB_MS, 1'b1);
        ce <= 1'b0;
        hold <= 1'b0;
        repeat (8) tick();
        // A frozen block cannot see the release, so the read stays lit
        chk_val({illum, strobe}, 8'h02);
        ce <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) tick();
        chk_val({pass, fail, illum, strobe}, 8'h00);
        chk_val(rts, 1'b1);
        rst_n <= 1'b1;
        repeat (8) tick();
        chk_val({pass, fail, illum, strobe}, 8'h00);
        $display("Test freeze and reset done");
        chk_val(rts_drop, 1'b0);
        summarize();
    end
endmodule
